// >>> core/dpc_pkg.sv
// Shared constants, register map and carrier types for the dual probe capture block
package dpc_pkg;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  OFF_EDGE_CTRL = 8'h00;
	localparam logic [7:0]  OFF_ARM1      = 8'h04;
	localparam logic [7:0]  OFF_ARM2      = 8'h08;
	localparam logic [7:0]  OFF_STATE     = 8'h0C;
	localparam logic [7:0]  OFF_SRC_SEL   = 8'h10;
	localparam logic [7:0]  OFF_RES_BASE  = 8'h14;
	localparam logic [7:0]  OFF_LEVEL1    = 8'h24;
	localparam logic [7:0]  OFF_LEVEL2    = 8'h28;
	localparam logic [7:0]  OFF_RT_SEL    = 8'h2C;
	localparam logic [7:0]  OFF_IRQ_STAT  = 8'h30;
	localparam logic [7:0]  OFF_IRQ_MASK  = 8'h34;
	localparam logic [7:0]  OFF_LAT_BASE  = 8'h40;
	localparam logic [7:0]  OFF_STRIDE    = 8'h04;

	// ---------------------------------------------------------------
	// Edge control word fields and reset values
	// ---------------------------------------------------------------
	localparam int          EC_P1_RISE    = 0;
	localparam int          EC_P1_FALL    = 1;
	localparam int          EC_P2_RISE    = 2;
	localparam int          EC_P2_FALL    = 3;
	localparam int          EC_P1_CONT    = 5;
	localparam int          EC_P2_CONT    = 6;
	localparam int          EC_ACTIVATE   = 8;
	localparam logic [15:0] EDGE_CTRL_RST = 16'h0000;
	localparam logic [15:0] LEVEL_RST_MV  = 16'h1388;	// +5000 mV
	localparam logic        SRC_ACT_POS   = 1'b0;
	localparam logic        SRC_ALT       = 1'b1;
	localparam logic [5:0]  RT_SEL_RST    = 6'h00;
	localparam int          RT_BIT1_POS   = 6;
	localparam int          RT_BIT2_POS   = 7;
	localparam int          RT_SEL_W      = 3;
	localparam int          N_CHAN        = 2;
	localparam int          N_RES         = 4;

	// ---------------------------------------------------------------
	// Real-time bit source codes
	// ---------------------------------------------------------------
	localparam logic [2:0]  RT_P1_STATE   = 3'h0;
	localparam logic [2:0]  RT_P2_STATE   = 3'h1;
	localparam logic [2:0]  RT_P1_RISE    = 3'h2;
	localparam logic [2:0]  RT_P1_FALL    = 3'h3;
	localparam logic [2:0]  RT_P2_RISE    = 3'h4;
	localparam logic [2:0]  RT_P2_FALL    = 3'h5;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_PARAM = 2'b00,
		PH_ENTER = 2'b01,
		PH_OPER  = 2'b11
	} dpc_phase_e;

	typedef struct packed {
		logic       state;
		logic [1:0] latched;
		logic [1:0] evt;
	} dpc_chan_s;

endpackage : dpc_pkg

// >>> core/dpc_probe_chan.sv
// One probe channel: level trigger, edge detect, single-shot capture and latched flags
`timescale 1ns/1ps
module dpc_probe_chan #(
	parameter int LVL_W = 16,
	parameter int POS_W = 32
) (
	input  wire logic                    clk_sys,
	input  wire logic                    nrst,
	input  wire logic                    present,
	input  wire logic                    active,
	input  wire logic                    activate,
	input  wire logic                    arm,
	input  wire logic                    arm_set,
	input  wire logic                    arm_clr,
	input  wire logic [1:0]              edge_en,
	input  wire logic signed [LVL_W-1:0] trig_sample,
	input  wire logic signed [LVL_W-1:0] trig_level,
	input  wire logic [POS_W-1:0]        cap_value,
	output dpc_pkg::dpc_chan_s           stat,
	output logic [POS_W-1:0]             res_rise,
	output logic [POS_W-1:0]             res_fall
);

	// ---------------------------------------------------------------
	// Trigger, edges and capture
	// ---------------------------------------------------------------
	logic             state_r, state_nxt;
	logic             done_r, done_nxt;
	logic [1:0]       lat_r, lat_nxt;
	logic [1:0]       evt_r, evt_nxt;
	logic [POS_W-1:0] rise_r, rise_nxt;
	logic [POS_W-1:0] fall_r, fall_nxt;
	logic             take;

	// Next values; a capture in the clear cycle still latches
	always_comb
	begin
		state_nxt = present && (trig_sample >= trig_level);
		take      = active && arm && !done_r;
		evt_nxt   = {take && edge_en[1] && !state_nxt && state_r,
		             take && edge_en[0] && state_nxt && !state_r};
		done_nxt  = done_r;
		if (|evt_nxt)
			done_nxt = 1'b1;
		else if (arm_set || activate)
			done_nxt = 1'b0;
		lat_nxt   = (arm_clr ? 2'h0 : lat_r) | evt_nxt;
		rise_nxt  = evt_nxt[0] ? cap_value : rise_r;
		fall_nxt  = evt_nxt[1] ? cap_value : fall_r;
	end

	// State registers
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			state_r <= 1'b0;
			done_r  <= 1'b0;
			lat_r   <= 2'h0;
			evt_r   <= 2'h0;
			rise_r  <= '0;
			fall_r  <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			done_r  <= done_nxt;
			lat_r   <= lat_nxt;
			evt_r   <= evt_nxt;
			rise_r  <= rise_nxt;
			fall_r  <= fall_nxt;
		end
	end

	assign stat.state   = state_r;
	assign stat.latched = lat_r;
	assign stat.evt     = evt_r;
	assign res_rise     = rise_r;
	assign res_fall     = fall_r;

endmodule : dpc_probe_chan

// >>> core/dpc_rt_map.sv
// Maps probe states and latched flags onto the two real-time bits of the control word
`timescale 1ns/1ps
module dpc_rt_map (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic [5:0]  src,
	input  wire logic [5:0]  sel,
	output logic [15:0]      conn_word
);

	logic [15:0] word_r, word_nxt;

	// Pick one source bit; unused codes read as zero
	function automatic logic pick(input logic [5:0] s, input logic [2:0] code);
		pick = (code <= dpc_pkg::RT_P2_FALL) ? s[code] : 1'b0;
	endfunction : pick

	// Only bits 6 and 7 carry data; the rest stay zero for merging
	always_comb
	begin
		word_nxt = 16'h0000;
		word_nxt[dpc_pkg::RT_BIT1_POS] = pick(src, sel[2:0]);
		word_nxt[dpc_pkg::RT_BIT2_POS] = pick(src, sel[5:3]);
	end

	// Output register
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			word_r <= 16'h0000;
		else
			word_r <= word_nxt;
	end

	assign conn_word = word_r;

endmodule : dpc_rt_map

// >>> core/dpc_top.sv
// Dual probe position capture: APB registers, phase control, channels and interrupts
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
module dpc_top #(
	parameter int LVL_W = 16,
	parameter int POS_W = 32
) (
	input  wire logic                    clk_sys,
	input  wire logic                    nrst,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic signed [LVL_W-1:0] probe_trigger_input_1,
	input  wire logic signed [LVL_W-1:0] probe_trigger_input_2,
	input  wire logic [POS_W-1:0]        actual_position,
	input  wire logic [POS_W-1:0]        alt_capture_value,
	input  wire logic                    ext_io_fitted,
	input  wire logic                    operation_phase,
	output logic [15:0]                  conn_ctrl_rt_word,
	output logic                         irq
);

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic [15:0]          edge_ctrl_r, edge_ctrl_nxt;
	logic [1:0]           arm_r, arm_nxt;
	logic [1:0]           src_sel_r, src_sel_nxt;
	logic [15:0]          level_r [dpc_pkg::N_CHAN];
	logic [15:0]          level_nxt [dpc_pkg::N_CHAN];
	logic [5:0]           rt_sel_r, rt_sel_nxt;
	logic [3:0]           irq_stat_r, irq_stat_nxt;
	logic [3:0]           irq_mask_r, irq_mask_nxt;
	logic                 irq_r, irq_nxt;
	logic [31:0]          prdata_r, prdata_nxt;
	logic                 pready_r, pready_nxt;
	logic                 pslverr_r, pslverr_nxt;
	dpc_pkg::dpc_phase_e  phase_r, phase_nxt;

	// ---------------------------------------------------------------
	// Channel wiring
	// ---------------------------------------------------------------
	dpc_pkg::dpc_chan_s   chan [dpc_pkg::N_CHAN];
	logic [POS_W-1:0]     res [dpc_pkg::N_RES];
	logic [POS_W-1:0]     cap_value [dpc_pkg::N_CHAN];
	logic signed [LVL_W-1:0] trig_in [dpc_pkg::N_CHAN];
	logic [1:0]           arm_set, arm_clr;
	logic [3:0]           evt_all, lat_all;
	logic                 wr_en, rd_pend, mapped;
	logic                 active, activate;

	// Address hit test, shared by read and write paths
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'b00) &&
		            ((a <= dpc_pkg::OFF_IRQ_MASK) ||
		             ((a >= dpc_pkg::OFF_LAT_BASE) &&
		              (a < dpc_pkg::OFF_LAT_BASE + 8'(dpc_pkg::N_RES) * dpc_pkg::OFF_STRIDE)));
	endfunction : is_mapped

	assign trig_in[0] = probe_trigger_input_1;
	assign trig_in[1] = probe_trigger_input_2;
	assign evt_all    = {chan[1].evt, chan[0].evt};
	assign lat_all    = {chan[1].latched, chan[0].latched};

	// ---------------------------------------------------------------
	// Phase tracking
	// ---------------------------------------------------------------

	// Probes wake up on every parameter-to-operation change, not on bit 8
	always_comb
	begin
		phase_nxt = phase_r;
		unique case (phase_r)
			dpc_pkg::PH_PARAM: if (operation_phase) phase_nxt = dpc_pkg::PH_ENTER;
			dpc_pkg::PH_ENTER: phase_nxt = operation_phase ? dpc_pkg::PH_OPER : dpc_pkg::PH_PARAM;
			dpc_pkg::PH_OPER:  if (!operation_phase) phase_nxt = dpc_pkg::PH_PARAM;
			default:           phase_nxt = dpc_pkg::PH_PARAM;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			phase_r <= dpc_pkg::PH_PARAM;
		else
			phase_r <= phase_nxt;
	end

	assign activate = (phase_r == dpc_pkg::PH_ENTER);
	assign active   = (phase_r == dpc_pkg::PH_OPER);

	// ---------------------------------------------------------------
	// Probe channels
	// ---------------------------------------------------------------
	generate
		for (genvar i = 0; i < dpc_pkg::N_CHAN; i++)
		begin : g_chan
			// Source mux: actual position unless software picks the alternate
			assign cap_value[i] = (src_sel_r[i] == dpc_pkg::SRC_ALT) ?
			                      alt_capture_value : actual_position;

			dpc_probe_chan #(
				.LVL_W       (LVL_W),
				.POS_W       (POS_W)
			) u_chan (
				.clk_sys     (clk_sys),
				.nrst        (nrst),
				.present     ((i == 0) || ext_io_fitted),
				.active      (active),
				.activate    (activate),
				.arm         (arm_r[i]),
				.arm_set     (arm_set[i]),
				.arm_clr     (arm_clr[i]),
				.edge_en     (edge_ctrl_r[2*i+1 -: 2]),
				.trig_sample (trig_in[i]),
				.trig_level  (LVL_W'(level_r[i])),
				.cap_value   (cap_value[i]),
				.stat        (chan[i]),
				.res_rise    (res[2*i]),
				.res_fall    (res[2*i+1])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Real-time bit mapping
	// ---------------------------------------------------------------
	dpc_rt_map u_rt_map (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.src       ({chan[1].latched, chan[0].latched, chan[1].state, chan[0].state}),
		.sel       (rt_sel_r),
		.conn_word (conn_ctrl_rt_word)
	);

	// ---------------------------------------------------------------
	// APB slave and register file
	// ---------------------------------------------------------------
	assign wr_en   = psel && penable && pwrite && pready_r;
	assign rd_pend = psel && penable && !pwrite && !pready_r;
	assign mapped  = is_mapped(paddr);

	// One wait state: read data is registered so outputs stay on flops
	always_comb
	begin
		edge_ctrl_nxt = edge_ctrl_r;
		arm_nxt       = arm_r;
		src_sel_nxt   = src_sel_r;
		level_nxt     = level_r;
		rt_sel_nxt    = rt_sel_r;
		irq_mask_nxt  = irq_mask_r;
		arm_set       = 2'b00;
		arm_clr       = 2'b00;
		pready_nxt    = psel && penable && !pready_r;
		pslverr_nxt   = psel && penable && !pready_r && !mapped;
		prdata_nxt    = 32'h0000_0000;
		if (wr_en && mapped)
		begin
			unique case (paddr)
				// Bits 5, 6 and 8 are stored but steer nothing
				dpc_pkg::OFF_EDGE_CTRL: edge_ctrl_nxt = pwdata[15:0];
				dpc_pkg::OFF_ARM1:
				begin
					arm_nxt[0] = pwdata[0];
					arm_set[0] = pwdata[0] && !arm_r[0];
					arm_clr[0] = !pwdata[0];
				end
				dpc_pkg::OFF_ARM2:
				begin
					arm_nxt[1] = pwdata[0];
					arm_set[1] = pwdata[0] && !arm_r[1];
					arm_clr[1] = !pwdata[0];
				end
				dpc_pkg::OFF_SRC_SEL:  src_sel_nxt  = pwdata[1:0];
				dpc_pkg::OFF_LEVEL1:   level_nxt[0] = pwdata[15:0];
				dpc_pkg::OFF_LEVEL2:   level_nxt[1] = pwdata[15:0];
				dpc_pkg::OFF_RT_SEL:   rt_sel_nxt   = pwdata[5:0];
				dpc_pkg::OFF_IRQ_MASK: irq_mask_nxt = pwdata[3:0];
				default:               ;
			endcase
		end
		if (rd_pend && mapped)
		begin
			if (paddr >= dpc_pkg::OFF_LAT_BASE)
				prdata_nxt[0] = lat_all[2'((paddr - dpc_pkg::OFF_LAT_BASE) >> 2)];
			else if ((paddr >= dpc_pkg::OFF_RES_BASE) && (paddr < dpc_pkg::OFF_LEVEL1))
				prdata_nxt = 32'(res[2'((paddr - dpc_pkg::OFF_RES_BASE) >> 2)]);
			else
			begin
				unique case (paddr)
					dpc_pkg::OFF_EDGE_CTRL: prdata_nxt[15:0] = edge_ctrl_r;
					dpc_pkg::OFF_ARM1:      prdata_nxt[0]    = arm_r[0];
					dpc_pkg::OFF_ARM2:      prdata_nxt[0]    = arm_r[1];
					dpc_pkg::OFF_STATE:     prdata_nxt[1:0]  = {chan[1].state, chan[0].state};
					dpc_pkg::OFF_SRC_SEL:   prdata_nxt[1:0]  = src_sel_r;
					dpc_pkg::OFF_LEVEL1:    prdata_nxt[15:0] = level_r[0];
					dpc_pkg::OFF_LEVEL2:    prdata_nxt[15:0] = level_r[1];
					dpc_pkg::OFF_RT_SEL:    prdata_nxt[5:0]  = rt_sel_r;
					dpc_pkg::OFF_IRQ_STAT:  prdata_nxt[3:0]  = irq_stat_r;
					dpc_pkg::OFF_IRQ_MASK:  prdata_nxt[3:0]  = irq_mask_r;
					default:                prdata_nxt       = 32'h0000_0000;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Interrupt status
	// ---------------------------------------------------------------

	// Write one to clear; a capture in the same cycle wins
	always_comb
	begin
		irq_stat_nxt = irq_stat_r;
		if (wr_en && (paddr == dpc_pkg::OFF_IRQ_STAT))
			irq_stat_nxt = irq_stat_nxt & ~pwdata[3:0];
		irq_stat_nxt = irq_stat_nxt | evt_all;
		irq_nxt      = |(irq_stat_nxt & irq_mask_nxt);
	end

	// Register and interrupt flops
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			edge_ctrl_r <= dpc_pkg::EDGE_CTRL_RST;
			arm_r       <= 2'b00;
			src_sel_r   <= {2{dpc_pkg::SRC_ACT_POS}};
			level_r[0]  <= dpc_pkg::LEVEL_RST_MV;
			level_r[1]  <= dpc_pkg::LEVEL_RST_MV;
			rt_sel_r    <= dpc_pkg::RT_SEL_RST;
			irq_stat_r  <= 4'h0;
			irq_mask_r  <= 4'h0;
			irq_r       <= 1'b0;
			prdata_r    <= 32'h0000_0000;
			pready_r    <= 1'b0;
			pslverr_r   <= 1'b0;
		end
		else
		begin
			edge_ctrl_r <= edge_ctrl_nxt;
			arm_r       <= arm_nxt;
			src_sel_r   <= src_sel_nxt;
			level_r     <= level_nxt;
			rt_sel_r    <= rt_sel_nxt;
			irq_stat_r  <= irq_stat_nxt;
			irq_mask_r  <= irq_mask_nxt;
			irq_r       <= irq_nxt;
			prdata_r    <= prdata_nxt;
			pready_r    <= pready_nxt;
			pslverr_r   <= pslverr_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign irq     = irq_r;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	chk_p1_trigger: assert property (
		chan[0].state == $past(probe_trigger_input_1 >= $signed(LVL_W'(level_r[0]))))
		else $error("probe 1 state does not follow level compare");
	chk_p2_absent: assert property (
		!$past(ext_io_fitted) |-> !chan[1].state && (chan[1].evt == 2'b00))
		else $error("probe 2 active without extended io");
	chk_single_shot: assert property (
		(|chan[0].evt) |=> (chan[0].evt == 2'b00) [*8])
		else $error("probe 1 captured twice without rearm");
	chk_edge_gate: assert property (
		chan[0].evt[0] |-> $past(edge_ctrl_r[dpc_pkg::EC_P1_RISE] && arm_r[0]))
		else $error("probe 1 rise capture while disabled");
	chk_param_quiet: assert property (
		!$past(active) |-> (evt_all == 4'h0))
		else $error("capture outside operation phase");
	chk_result_store: assert property (
		chan[1].evt[1] |-> res[3] == $past(cap_value[1]))
		else $error("probe 2 fall result not stored");
	chk_latch_set: assert property (
		(|evt_all) |-> ((lat_all & evt_all) == evt_all))
		else $error("latched flag missing on capture");
	chk_latch_clear: assert property (
		arm_clr[0] && (chan[0].evt == 2'b00) |=> !(|chan[0].evt) |-> (chan[0].latched == 2'b00))
		else $error("latched flags survive arm clear");
	chk_src_default: assert property (
		$rose(nrst) |-> (src_sel_r == 2'b00))
		else $error("capture source not actual position after reset");
	chk_rt_bit1: assert property (
		($past(rt_sel_r[2:0]) == dpc_pkg::RT_P1_STATE) |->
		conn_ctrl_rt_word[dpc_pkg::RT_BIT1_POS] == $past(chan[0].state))
		else $error("real-time bit 1 does not carry probe 1 state");
	chk_unarmed_quiet: assert property (
		!$past(arm_r[1]) |-> (chan[1].evt == 2'b00))
		else $error("probe 2 captured while unarmed");

	cov_p1_rise: cover property (chan[0].evt[0]);
	cov_p2_fall: cover property (chan[1].evt[1]);
	cov_rearm: cover property (arm_clr[0] ##[1:20] arm_set[0]);
	cov_irq: cover property ($rose(irq));

endmodule : dpc_top

// >>> bench/dpc_master_model.sv
// Behavioural model of the fieldbus master driving the probe register bus
`timescale 1ns/1ps
module dpc_master_model (
	input  wire logic        clk_sys,
	input  wire logic        pready,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	// Bus idle from time zero so nothing is requested during reset
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// ---------------------------------------------------------------
	// Transfers
	// ---------------------------------------------------------------
	// One transfer; no fixed latency assumed, the bench timeout cuts a hang
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	// Continuous bits are never requested, hardware has single shot only
	task automatic set_edges(input logic [15:0] m);
		xfer(1'b1, dpc_pkg::OFF_EDGE_CTRL, {16'h0, m & 16'hFF9F});
	endtask : set_edges

	// Arming is a write of one to the channel's arm word
	task automatic arm(input logic [7:0] a);
		xfer(1'b1, a, 32'h1);
	endtask : arm

	// New cycle needs a clear before the next set
	task automatic rearm(input logic [7:0] a);
		xfer(1'b1, a, 32'h0);
		xfer(1'b1, a, 32'h1);
	endtask : rearm
endmodule : dpc_master_model

// >>> bench/dual_probe_position_capture_test.sv
// Self-checking bench for the dual probe position capture block
`timescale 1ns/1ps
module dual_probe_position_capture_test;
	logic               clk_sys = 1'b0;
	logic               nrst = 1'b0;
	logic               psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, pos, alt, seed, p1;
	logic signed [15:0] in1 = 16'sd0;
	logic signed [15:0] in2 = 16'sd0;
	logic               ext_io = 1'b1;
	logic               op_ph = 1'b0;
	logic [15:0]        conn;
	logic [5:0]         rt_exp;
	logic [32:0]        exp_q[$];
	logic [32:0]        e;
	int                 err_total = 0;
	int                 checked = 0;
	int                 cyc = 0;

	always #5 clk_sys = ~clk_sys;

	dpc_master_model m (.clk_sys(clk_sys), .pready(pready), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	dpc_top dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.probe_trigger_input_1(in1), .probe_trigger_input_2(in2), .actual_position(pos),
		.alt_capture_value(alt), .ext_io_fitted(ext_io), .operation_phase(op_ph),
		.conn_ctrl_rt_word(conn), .irq(irq));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Expectation noted first, the monitor pairs it with the answer
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
		exp_q.push_back({err, exp});
		m.xfer(1'b0, a, 32'h0);
	endtask : rd_chk

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wait_cyc

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// Read answers stand one cycle only, so they are taken at the pready edge
	always @(posedge clk_sys)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			e = exp_q.pop_front();
			check("prdata", prdata, e[31:0]);
			check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
		end
	end

	// Hang guard, far above the few hundred cycles of the sequence
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			wrap_up();
		end
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		pos = 32'h0;
		alt = 32'h0;
		seed = 32'h71d9;
		wait_cyc(12);
		nrst <= 1'b1;
		rd_chk(dpc_pkg::OFF_EDGE_CTRL, 32'h0);
		rd_chk(dpc_pkg::OFF_LEVEL1, 32'h1388);
		rd_chk(dpc_pkg::OFF_SRC_SEL, 32'h0);
		rd_chk(8'h38, 32'h0, 1'b1);
		$display("test reset values done");
		// Edges in parameter phase must not capture
		m.set_edges(16'h0001);
		m.arm(dpc_pkg::OFF_ARM1);
		in1 <= 16'sd6000;
		wait_cyc(3);
		rd_chk(dpc_pkg::OFF_LAT_BASE, 32'h0);
		in1 <= 16'sd0;
		$display("test parameter phase done");
		// Activation bit left set on purpose, it has no effect
		op_ph <= 1'b1;
		m.set_edges(16'h010F);
		rd_chk(dpc_pkg::OFF_EDGE_CTRL, 32'h010F);
		m.xfer(1'b1, dpc_pkg::OFF_IRQ_MASK, 32'hF);
		seed = lfsr(seed);
		pos <= seed;
		p1 = seed;
		in1 <= 16'sd5000;
		wait_cyc(3);
		pos <= ~seed;
		check("irq", {31'h0, irq}, 32'h1);
		rd_chk(dpc_pkg::OFF_RES_BASE, p1);
		rd_chk(dpc_pkg::OFF_LAT_BASE, 32'h1);
		rd_chk(dpc_pkg::OFF_STATE, 32'h1);
		rd_chk(dpc_pkg::OFF_IRQ_STAT, 32'h1);
		// Every source code on both real-time bits; 6 and 7 read zero
		rt_exp = 6'b000101;
		for (int c = 0; c < 8; c++)
		begin
			m.xfer(1'b1, dpc_pkg::OFF_RT_SEL, {26'h0, c[2:0], c[2:0]});
			wait_cyc(4);
			check("conn_word", {16'h0, conn}, {16'h0, 8'h0, {2{c < 6 ? rt_exp[c] : 1'b0}}, 6'h0});
		end
		$display("test rise capture done");
		// Falling edge is enabled but the shot is already spent
		in1 <= 16'sd4999;
		wait_cyc(3);
		rd_chk(dpc_pkg::OFF_RES_BASE + 8'h04, 32'h0);
		rd_chk(dpc_pkg::OFF_LAT_BASE + 8'h04, 32'h0);
		m.xfer(1'b1, dpc_pkg::OFF_IRQ_STAT, 32'h1);
		wait_cyc(2);
		check("irq", {31'h0, irq}, 32'h0);
		m.xfer(1'b1, dpc_pkg::OFF_ARM1, 32'h0);
		rd_chk(dpc_pkg::OFF_LAT_BASE, 32'h0);
		m.arm(dpc_pkg::OFF_ARM1);
		m.xfer(1'b1, dpc_pkg::OFF_IRQ_MASK, 32'h0);
		seed = lfsr(seed);
		pos <= seed;
		p1 = seed;
		in1 <= 16'sd7000;
		wait_cyc(3);
		pos <= ~seed;
		check("irq", {31'h0, irq}, 32'h0);
		// Input climbs from below the level, so this rearmed shot is a rise
		rd_chk(dpc_pkg::OFF_RES_BASE, p1);
		rd_chk(dpc_pkg::OFF_RES_BASE + 8'h04, 32'h0);
		rd_chk(dpc_pkg::OFF_IRQ_STAT, 32'h1);
		$display("test rearm done");
		// Probe 2: only falling edge enabled, alternate source selected
		m.set_edges(16'h0008);
		m.xfer(1'b1, dpc_pkg::OFF_SRC_SEL, 32'h2);
		m.arm(dpc_pkg::OFF_ARM2);
		seed = lfsr(seed);
		alt <= seed;
		p1 = seed;
		in2 <= 16'sd6000;
		wait_cyc(3);
		rd_chk(dpc_pkg::OFF_RES_BASE + 8'h08, 32'h0);
		rd_chk(dpc_pkg::OFF_LAT_BASE + 8'h08, 32'h0);
		rd_chk(dpc_pkg::OFF_STATE, 32'h3);
		in2 <= -16'sd100;
		wait_cyc(3);
		alt <= ~seed;
		rd_chk(dpc_pkg::OFF_RES_BASE + 8'h0C, p1);
		rd_chk(dpc_pkg::OFF_LAT_BASE + 8'h0C, 32'h1);
		$display("test probe 2 done");
		// Without the extension the second probe reads as absent
		ext_io <= 1'b0;
		in2 <= 16'sd6000;
		wait_cyc(3);
		rd_chk(dpc_pkg::OFF_STATE, 32'h1);
		$display("test no extension done");
		wait_cyc(2);
		wrap_up();
	end
endmodule : dual_probe_position_capture_test
